// File: design/ams_defs.vh
// Register offsets, field positions, reset values and timing counts for the mode sequencer
`ifndef AMS_DEFS_VH
`define AMS_DEFS_VH
// Register byte offsets
`define AMS_REG_CTRL      12'h000
`define AMS_REG_CHOP      12'h004
`define AMS_REG_CLOCK     12'h008
`define AMS_REG_DET_CFG   12'h00c
`define AMS_REG_THR_UPPER 12'h010
`define AMS_REG_THR_LOWER 12'h014
`define AMS_REG_CMD       12'h018
`define AMS_REG_STATUS    12'h01c
`define AMS_REG_SAMPLE    12'h020
`define AMS_REG_RESULTS   12'h024
// Field positions
`define AMS_CHOP_EN_BIT   0
`define AMS_CHOP_DLY_LSB  4
`define AMS_CLK_PWR_LSB   0
`define AMS_CLK_CHEN_LSB  8
`define AMS_CLK_RATIO_LSB 16
`define AMS_DET_EN_BIT    0
`define AMS_DET_ALL_BIT   1
`define AMS_DET_LEN_LSB   4
`define AMS_DET_NUM_LSB   8
`define AMS_CTRL_PHASE_BIT 0
`define AMS_CTRL_TEST_BIT  1
// Reset values
`define AMS_RST_CHOP      32'h0000_0000
`define AMS_RST_CLOCK     32'h0004_ff02
`define AMS_RST_DET_CFG   32'h0000_0000
`define AMS_RST_THR       24'h00_0000
`define AMS_RST_CTRL      32'h0000_0000
// Commands
`define AMS_CMD_STANDBY   16'h0022
`define AMS_CMD_WAKEUP    16'h0033
// Timing counts in modulator periods; chop settle count in conversions
`define AMS_FIRST_EXTRA   44
`define AMS_WAKE_SETTLE   8
`define AMS_CHOP_SETTLES  3
// Detect oscillator: nominal sample rate in samples per second, and pclk rate in Hz
`define AMS_DET_RATE_SPS  2700
`define AMS_CLK_HZ        40000000
`endif

// File: design/ams_sequencer.v
// Mode sequencer: conversion timing, chop, power level, standby and current detect
`timescale 1ns/1ps
`include "ams_defs.vh"
module ams_sequencer #(
  parameter NCH        = 8,
  parameter RSL_CYCLES = 2048,
  // Detect sample spacing in pclk cycles; default from the nominal rate
  parameter DET_PERIOD = `AMS_CLK_HZ / `AMS_DET_RATE_SPS,
  parameter MOD_DIV    = 5
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [11:0]          paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  input  wire                 sync_reset_n,
  input  wire [NCH*24-1:0]    detect_samples,
  output reg                  data_ready_n,
  output wire                 result_strobe,
  output wire                 chop_polarity,
  output wire                 filter_reset,
  output wire                 modulator_run,
  output wire [1:0]           power_level_select,
  output wire                 reference_enable,
  output wire                 phase_cal_enable,
  output wire                 dc_test_enable,
  output wire                 device_reset
);
  // Power levels
  localparam [1:0] HIGH_RESOLUTION_LEVEL = 2'h2;
  localparam [1:0] LOW_POWER_LEVEL       = 2'h1;
  localparam [1:0] VERY_LOW_POWER_LEVEL  = 2'h0;
  // Top states
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_STBY  = 3'h1;
  localparam [2:0] ST_WAKE  = 3'h2;
  localparam [2:0] ST_DET   = 3'h3;
  localparam [2:0] ST_RST   = 3'h4;

  //////////////////////////////////////////////////////////////////////////////
  // Lookup tables for coded fields
  // Oversampling ratio, code 0..7 -> 128..16384
  function [15:0] ratio_lut;
    input [2:0] c;
    begin
      ratio_lut = 16'h0080 << c;
    end
  endfunction
  // Chop delay, 2^(c+1) modulator periods: 2..65536
  function [16:0] dly_lut;
    input [3:0] c;
    begin
      dly_lut = 17'h00002 << c;
    end
  endfunction
  // Detect length, (c+1)*128 -> 128..896, top code 3584
  function [11:0] len_lut;
    input [2:0] c;
    begin
      len_lut = (c == 3'h7) ? 12'he00 : {2'h0, c + 3'h1, 7'h00};
    end
  endfunction
  // Hit count, code c needs c+1 hits
  function [3:0] num_lut;
    input [2:0] c;
    begin
      num_lut = {1'b0, c} + 4'h1;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // APB register file
  reg  [31:0] ctrl_q, chop_q, clock_q, det_q;
  reg  [23:0] thr_q;
  reg  [2:0]  state_q, state_d;
  reg  [15:0] results_q;
  wire        wr_en = psel & penable & pwrite;
  wire        cmd_wr = wr_en && (paddr == `AMS_REG_CMD);
  wire        chop_enable_bit = chop_q[`AMS_CHOP_EN_BIT];
  wire [3:0]  chop_settle_delay = chop_q[`AMS_CHOP_DLY_LSB +: 4];
  wire [NCH-1:0] channel_enable_bits = clock_q[`AMS_CLK_CHEN_LSB +: NCH];
  wire [2:0]  ratio_code = clock_q[`AMS_CLK_RATIO_LSB +: 3];
  wire        detect_enable_bit = det_q[`AMS_DET_EN_BIT];
  wire        detect_all_channels = det_q[`AMS_DET_ALL_BIT];
  wire [2:0]  detect_sample_length = det_q[`AMS_DET_LEN_LSB +: 3];
  wire [2:0]  detect_hit_count = det_q[`AMS_DET_NUM_LSB +: 3];
  wire [23:0] detect_threshold = thr_q;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign power_level_select = clock_q[`AMS_CLK_PWR_LSB +: 2];

  // Register writes; a long sync reset returns all but the results count to defaults
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `AMS_RST_CTRL;
      chop_q  <= `AMS_RST_CHOP;
      clock_q <= `AMS_RST_CLOCK;
      det_q   <= `AMS_RST_DET_CFG;
      thr_q   <= `AMS_RST_THR;
    end else if (state_q == ST_RST) begin
      ctrl_q  <= `AMS_RST_CTRL;
      chop_q  <= `AMS_RST_CHOP;
      clock_q <= `AMS_RST_CLOCK;
      det_q   <= `AMS_RST_DET_CFG;
      thr_q   <= `AMS_RST_THR;
    end else if (wr_en) begin
      case (paddr)
        `AMS_REG_CTRL:      ctrl_q <= pwdata;
        `AMS_REG_CHOP:      chop_q <= pwdata;
        `AMS_REG_CLOCK:     clock_q <= pwdata;
        `AMS_REG_DET_CFG:   det_q <= pwdata;
        `AMS_REG_THR_UPPER: thr_q[23:16] <= pwdata[7:0];
        `AMS_REG_THR_LOWER: thr_q[15:0] <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read mux; detect samples are not readable here
  always @* begin
    case (paddr)
      `AMS_REG_CTRL:      prdata = ctrl_q;
      `AMS_REG_CHOP:      prdata = chop_q;
      `AMS_REG_CLOCK:     prdata = clock_q;
      `AMS_REG_DET_CFG:   prdata = det_q;
      `AMS_REG_THR_UPPER: prdata = {24'h00_0000, thr_q[23:16]};
      `AMS_REG_THR_LOWER: prdata = {16'h0000, thr_q[15:0]};
      `AMS_REG_STATUS:    prdata = {28'h000_0000, chop_polarity, state_q};
      `AMS_REG_RESULTS:   prdata = {16'h0000, results_q};
      default:            prdata = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sync pin: two-flop synchroniser, then low-width measurement
  reg        sync_m_q, sync_s_q, sync_d_q;
  reg [15:0] low_cnt_q;
  reg        long_low_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_m_q   <= 1'b1;
      sync_s_q   <= 1'b1;
      sync_d_q   <= 1'b1;
      low_cnt_q  <= 16'h0000;
      long_low_q <= 1'b0;
    end else begin
      sync_m_q <= sync_reset_n;
      sync_s_q <= sync_m_q;
      sync_d_q <= sync_s_q;
      if (sync_s_q) begin
        low_cnt_q  <= 16'h0000;
        long_low_q <= 1'b0;
      end else if (low_cnt_q >= RSL_CYCLES[15:0]) begin
        long_low_q <= 1'b1;
      end else begin
        low_cnt_q <= low_cnt_q + 16'h0001;
      end
    end
  end
  wire sync_fall  = sync_d_q & ~sync_s_q;
  // Short pulse known only at the rising edge, when width is below limit
  wire sync_short = ~sync_d_q & sync_s_q & ~long_low_q;

  //////////////////////////////////////////////////////////////////////////////
  // Modulator clock enable divided from pclk
  reg [7:0] mdiv_q;
  wire      mod_tick = (mdiv_q == MOD_DIV[7:0] - 8'h01);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) mdiv_q <= 8'h00;
    else if (mod_tick) mdiv_q <= 8'h00;
    else mdiv_q <= mdiv_q + 8'h01;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion timer
  reg  [2:0]  ratio_prev_q;
  reg  [19:0] tmr_q;
  reg  [1:0]  phase_q;     // 0 settling delay, 1 converting
  reg  [1:0]  conv_q;      // internal conversions since swap
  reg         pol_q;
  reg         first_q;     // first chop result pending
  reg         strobe_q;
  reg         frst_q;
  wire [15:0] ratio = ratio_lut(ratio_code);
  wire [19:0] dly = {3'h0, dly_lut(chop_settle_delay)};
  wire        restart = chop_enable_bit && (sync_fall || ratio_code != ratio_prev_q);
  wire        running = (state_q == ST_RUN);
  wire        tmr_done = (tmr_q == 20'h00001);
  assign chop_polarity = pol_q;
  assign filter_reset  = frst_q;
  assign result_strobe = strobe_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_prev_q <= 3'h0;
      tmr_q      <= 20'h00001;
      phase_q    <= 2'h0;
      conv_q     <= 2'h0;
      pol_q      <= 1'b0;
      first_q    <= 1'b1;
      strobe_q   <= 1'b0;
      frst_q     <= 1'b0;
    end else begin
      strobe_q   <= 1'b0;
      frst_q     <= 1'b0;
      ratio_prev_q <= ratio_code;
      if (!running || restart) begin
        // Restart: first chop result pays an extra 44 periods up front
        tmr_q   <= chop_enable_bit ? dly + 20'd`AMS_FIRST_EXTRA : {4'h0, ratio};
        phase_q <= 2'h0;
        conv_q  <= 2'h0;
        pol_q   <= 1'b0;
        first_q <= 1'b1;
        frst_q  <= chop_enable_bit;
      end else if (mod_tick) begin
        if (!tmr_done) begin
          tmr_q <= tmr_q - 20'h00001;
        end else if (!chop_enable_bit) begin
          tmr_q    <= {4'h0, ratio};
          strobe_q <= 1'b1;
        end else if (phase_q == 2'h0) begin
          phase_q <= 2'h1;
          tmr_q   <= {4'h0, ratio};
        end else if (conv_q == `AMS_CHOP_SETTLES - 1) begin
          // Third conversion settled: swap inputs, reset filter, delay again
          pol_q   <= ~pol_q;
          frst_q  <= 1'b1;
          conv_q  <= 2'h0;
          phase_q <= 2'h0;
          tmr_q   <= dly;
          first_q <= 1'b0;
          // Sliding pair needs both polarities; first swap gives none
          strobe_q <= ~first_q;
        end else begin
          conv_q <= conv_q + 2'h1;
          tmr_q  <= {4'h0, ratio};
        end
      end
    end
  end
  assign phase_cal_enable = ctrl_q[`AMS_CTRL_PHASE_BIT] & ~chop_enable_bit;
  assign dc_test_enable   = ctrl_q[`AMS_CTRL_TEST_BIT] & ~chop_enable_bit;

  //////////////////////////////////////////////////////////////////////////////
  // Current detect: sample pacing, per-channel hit counters
  reg  [15:0] det_tmr_q;
  reg  [11:0] det_n_q;
  reg  [3:0]  hits_q [0:NCH-1];
  reg         det_hit_q;
  reg         det_end_q;
  wire        det_tick = (det_tmr_q == 16'h0000);
  wire [3:0]  need = num_lut(detect_hit_count);
  reg  [NCH-1:0] met;
  reg  [NCH-1:0] over;
  reg  [23:0] smp;
  integer     i;
  // Absolute value against threshold, strictly greater; most negative code still counts
  always @* begin
    smp = 24'h00_0000;
    for (i = 0; i < NCH; i = i + 1) begin
      met[i]  = (hits_q[i] >= need);
      smp     = detect_samples[i*24 +: 24];
      over[i] = (smp[23] ? (24'h00_0000 - smp) : smp) > detect_threshold;
    end
  end
  wire any_met = |(met & channel_enable_bits);
  wire all_met = ((met | ~channel_enable_bits) == {NCH{1'b1}}) & (|channel_enable_bits);
  wire det_ok  = detect_all_channels ? all_met : any_met;

  always @(posedge pclk or negedge presetn) begin : det_proc
    integer    k;
    if (!presetn) begin
      det_tmr_q <= 16'h0000;
      det_n_q   <= 12'h000;
      det_hit_q <= 1'b0;
      det_end_q <= 1'b0;
      for (k = 0; k < NCH; k = k + 1) hits_q[k] <= 4'h0;
    end else begin
      det_hit_q <= 1'b0;
      det_end_q <= 1'b0;
      if (state_q != ST_DET) begin
        det_tmr_q <= DET_PERIOD[15:0] - 16'h0001;
        det_n_q   <= 12'h000;
        for (k = 0; k < NCH; k = k + 1) hits_q[k] <= 4'h0;
      end else if (det_ok) begin
        det_hit_q <= 1'b1;
      end else if (det_tick) begin
        det_tmr_q <= DET_PERIOD[15:0] - 16'h0001;
        for (k = 0; k < NCH; k = k + 1) begin
          if (over[k] && hits_q[k] != 4'hf)
            hits_q[k] <= hits_q[k] + 4'h1;
        end
        if (det_n_q == len_lut(detect_sample_length) - 12'h001) begin
          det_end_q <= 1'b1;
          det_n_q   <= 12'h000;
        end else begin
          det_n_q <= det_n_q + 12'h001;
        end
      end else begin
        det_tmr_q <= det_tmr_q - 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Top mode machine
  reg [3:0] wake_q;
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN:  if (cmd_wr && pwdata[15:0] == `AMS_CMD_STANDBY) state_d = ST_STBY;
      ST_STBY: begin
        if (cmd_wr && pwdata[15:0] == `AMS_CMD_WAKEUP) state_d = ST_WAKE;
        else if (sync_short && detect_enable_bit) state_d = ST_DET;
      end
      ST_WAKE: if (wake_q == `AMS_WAKE_SETTLE) state_d = ST_RUN;
      ST_DET: begin
        if (det_hit_q || det_end_q || !detect_enable_bit) state_d = ST_STBY;
      end
      ST_RST:  if (sync_s_q) state_d = ST_WAKE;
      default: state_d = ST_STBY;
    endcase
    if (long_low_q) state_d = ST_RST;
  end

  // State, wake settle count, data-ready pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= ST_RUN;
      wake_q       <= 4'h0;
      data_ready_n <= 1'b1;
      results_q    <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (state_q != ST_WAKE) wake_q <= 4'h0;
      else if (mod_tick) wake_q <= wake_q + 4'h1;
      // Strobe or detection drops the pin; rises on next modulator tick
      if ((strobe_q && running) || det_hit_q) begin
        data_ready_n <= 1'b0;
        results_q    <= results_q + 16'h0001;
      end else if (mod_tick) begin
        data_ready_n <= 1'b1;
      end
    end
  end
  // Standby and detect leave the reference and modulators off
  assign modulator_run    = running;
  assign reference_enable = running | (state_q == ST_WAKE);
  assign device_reset     = (state_q == ST_RST);
endmodule // ams_sequencer

// File: sim/ams_sequencer_checker.sv
// Port-level assertions for the mode sequencer, bound to the top module
`timescale 1ns/1ps
module ams_sequencer_checker #(
  parameter int RSL_CYCLES = 16,
  parameter int MOD_DIV    = 2
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        sync_reset_n,
  input wire logic        data_ready_n,
  input wire logic        chop_polarity,
  input wire logic        filter_reset,
  input wire logic        modulator_run,
  input wire logic [1:0]  power_level_select,
  input wire logic        reference_enable,
  input wire logic        phase_cal_enable,
  input wire logic        dc_test_enable,
  input wire logic        device_reset
);
  localparam int RSL_LATE = RSL_CYCLES + 8;
  wire wr = psel & penable & pwrite;
  logic       chop_q;
  logic [7:0] low_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // Shadow of chop enable and length of the current sync low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_q <= 1'b0;
      low_q  <= 8'h00;
    end else begin
      if (device_reset)
        chop_q <= 1'b0;
      else if (wr && paddr == 12'h004)
        chop_q <= pwdata[0];
      low_q <= sync_reset_n ? 8'h00 : (low_q == 8'hff ? low_q : low_q + 8'h01);
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_stby_cmd;
    wr && paddr == 12'h018 && pwdata[15:0] == 16'h0022 && modulator_run;
  endsequence
  sequence s_wake_cmd;
    wr && paddr == 12'h018 && pwdata[15:0] == 16'h0033 && !modulator_run && !device_reset;
  endsequence
  sequence s_settle;
    !modulator_run[*8] ##[1:20] modulator_run;
  endsequence
  property p_data_ready_n;
    $fell(data_ready_n) && modulator_run |-> ##[1:MOD_DIV] data_ready_n;
  endproperty
  a_data_ready_n: assert property (p_data_ready_n) else $error("data ready low too long");
  property p_filt;
    chop_q && $changed(chop_polarity) |-> (filter_reset || $past(filter_reset)) or ##1 filter_reset;
  endproperty
  a_filt: assert property (p_filt) else $error("swap without filter reset");
  property p_cal;
    chop_q && $past(chop_q) |-> !phase_cal_enable;
  endproperty
  a_cal: assert property (p_cal) else $error("phase cal on in chop");
  property p_dc;
    chop_q && $past(chop_q) |-> !dc_test_enable;
  endproperty
  a_dc: assert property (p_dc) else $error("dc test on in chop");
  property p_pwr;
    wr && paddr == 12'h008 |=> power_level_select == $past(pwdata[1:0]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power level not taken");
  property p_stby;
    s_stby_cmd |-> ##[1:3] (!modulator_run && !reference_enable);
  endproperty
  a_stby: assert property (p_stby) else $error("standby not entered");
  property p_wake;
    s_wake_cmd |=> s_settle;
  endproperty
  a_wake: assert property (p_wake) else $error("wake settle wrong");
  property p_rst_long;
    low_q == RSL_LATE |-> device_reset;
  endproperty
  a_rst_long: assert property (p_rst_long) else $error("long sync low no reset");
  property p_rst_short;
    $rose(device_reset) |-> low_q >= RSL_CYCLES;
  endproperty
  a_rst_short: assert property (p_rst_short) else $error("reset on short pulse");
  property p_rst_exit;
    device_reset && sync_reset_n |-> ##[1:5] !device_reset;
  endproperty
  a_rst_exit: assert property (p_rst_exit) else $error("reset held after pin high");
endmodule // ams_sequencer_checker

bind ams_sequencer ams_sequencer_checker #(.RSL_CYCLES(RSL_CYCLES), .MOD_DIV(MOD_DIV))
  i_ams_sequencer_checker (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sync_reset_n(sync_reset_n),
  .data_ready_n(data_ready_n), .chop_polarity(chop_polarity), .filter_reset(filter_reset),
  .modulator_run(modulator_run), .power_level_select(power_level_select),
  .reference_enable(reference_enable), .phase_cal_enable(phase_cal_enable),
  .dc_test_enable(dc_test_enable), .device_reset(device_reset));

// File: sim/ams_host_model.sv
// Host-side model driving the sync/reset pin and the detect sample inputs
`timescale 1ns/1ps
module ams_host_model #(
  parameter int NCH = 8
) (
  input  wire logic             pclk,
  output logic                  sync_reset_n,
  output logic [NCH*24-1:0]     detect_samples
);
  // Pin idles high, samples start at zero
  initial begin
    sync_reset_n = 1'b1;
    detect_samples = '0;
  end
  // Low pulse; short ones enter detect only from standby
  task automatic pulse(input int cycles);
    @(posedge pclk);
    sync_reset_n <= 1'b0;
    repeat (cycles) @(posedge pclk);
    sync_reset_n <= 1'b1;
  endtask
  // Same value on every channel
  task automatic set_all(input logic [23:0] v);
    @(posedge pclk);
    detect_samples <= {NCH{v}};
  endtask
  // One channel differs from the rest
  task automatic set_one(input int ch, input logic [23:0] v);
    @(posedge pclk);
    detect_samples[ch*24 +: 24] <= v;
  endtask
endmodule // ams_host_model

// File: sim/ams_sequencer_tb.sv
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
module ams_sequencer_tb;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  wire  [31:0]  prdata;
  wire  [191:0] detect_samples;
  wire  [1:0]   power_level_select;
  wire          pready, pslverr, sync_reset_n, data_ready_n, result_strobe, chop_polarity;
  wire          filter_reset, modulator_run, reference_enable, phase_cal_enable;
  wire          dc_test_enable, device_reset;
  int           failures = 0;
  int           n_tests = 0;
  int           n;
  logic [31:0]  rd;
  always #12.5 pclk = ~pclk;
  ams_sequencer #(.RSL_CYCLES(16), .DET_PERIOD(4), .MOD_DIV(2)) i_ams_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_reset_n(sync_reset_n), .detect_samples(detect_samples),
    .data_ready_n(data_ready_n), .result_strobe(result_strobe), .chop_polarity(chop_polarity),
    .filter_reset(filter_reset), .modulator_run(modulator_run),
    .power_level_select(power_level_select), .reference_enable(reference_enable),
    .phase_cal_enable(phase_cal_enable), .dc_test_enable(dc_test_enable),
    .device_reset(device_reset));
  ams_host_model i_ams_host_model (.pclk(pclk), .sync_reset_n(sync_reset_n),
    .detect_samples(detect_samples));
  ////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; read data lands in rd at the completing edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 100);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the write land before callers look at outputs
    #1;
    if (i >= 100) begin
      failures++;
      test_done();
    end
  endtask
  // Cycles to the next data-ready fall, lim if none
  task automatic wfall(input int lim);
    logic prev;
    prev = data_ready_n;
    n = 0;
    while (n < lim) begin
      @(posedge pclk);
      #1;
      n++;
      if (prev === 1'b1 && data_ready_n === 1'b0)
        break;
      prev = data_ready_n;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, 12'h008, 32'h0);
    chk("clock reset", 32'h0004_ff02, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("chop reset", 32'h0, rd);
    apb(1'b1, 12'h0fc, 32'hffff_ffff);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  // Each power level, then fastest ratio: result every 128 ticks of 2 clocks
  task automatic t_cont();
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 12'h008, 32'h0000_ff00 | i);
      chk("power level", i, {30'h0, power_level_select});
    end
    // Ratio change does not restart continuous mode: old 2048-tick period runs out first
    wfall(5000);
    wfall(3000);
    chk("continuous period", 256, n);
  endtask
  // Chop with 2-tick delay: steady 2*(2+3*128), first 2*(44+2*386)
  task automatic t_chop();
    apb(1'b1, 12'h000, 32'h3);
    chk("cal before chop", 1, {31'h0, phase_cal_enable});
    apb(1'b1, 12'h004, 32'h1);
    @(posedge pclk);
    chk("cal in chop", 0, {31'h0, phase_cal_enable});
    chk("dc test in chop", 0, {31'h0, dc_test_enable});
    wfall(4000);
    wfall(2000);
    chk("chop period", 772, n);
    i_ams_host_model.pulse(2);
    wfall(4000);
    chk("first chop result", 1, n >= 1600 && n <= 1660);
    // Ratio 256 restarts chop: first result 2*(2+3*256)+44 ticks of 2 clocks
    apb(1'b1, 12'h008, 32'h0001_ff02);
    wfall(4000);
    chk("ratio restart", 1, n >= 3160 && n <= 3200);
    apb(1'b1, 12'h008, 32'h0000_ff02);
    apb(1'b1, 12'h004, 32'h0);
  endtask
  task automatic t_standby();
    apb(1'b1, 12'h018, 32'h22);
    repeat (3) @(posedge pclk);
    chk("run in standby", 0, {31'h0, modulator_run});
    chk("ref in standby", 0, {31'h0, reference_enable});
    apb(1'b0, 12'h008, 32'h0);
    chk("clock kept", 32'h0000_ff02, rd);
    apb(1'b1, 12'h018, 32'h33);
    n = 0;
    while (modulator_run !== 1'b1 && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("wake delay", 1, n >= 15 && n <= 24);
  endtask
  // Threshold 256, one hit over 128 samples
  task automatic t_detect();
    apb(1'b1, 12'h014, 32'h100);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h00c, 32'h1);
    apb(1'b1, 12'h018, 32'h22);
    i_ams_host_model.set_all(24'h000100);
    i_ams_host_model.pulse(4);
    wfall(800);
    chk("equal not hit", 800, n);
    i_ams_host_model.set_all(24'hfffe00);
    i_ams_host_model.pulse(4);
    wfall(800);
    chk("negative hit", 1, n < 800);
    repeat (20) @(posedge pclk);
    chk("back to standby", 0, {31'h0, modulator_run});
    apb(1'b1, 12'h00c, 32'h3);
    i_ams_host_model.set_one(0, 24'h000000);
    i_ams_host_model.pulse(4);
    wfall(800);
    chk("all channels", 800, n);
    apb(1'b1, 12'h00c, 32'h1);
    i_ams_host_model.pulse(4);
    wfall(800);
    chk("any channel", 1, n < 800);
    apb(1'b1, 12'h018, 32'h33);
    repeat (40) @(posedge pclk);
    i_ams_host_model.pulse(4);
    repeat (20) @(posedge pclk);
    chk("no detect from run", 1, {31'h0, modulator_run});
  endtask
  task automatic t_reset();
    i_ams_host_model.pulse(40);
    repeat (40) @(posedge pclk);
    chk("reset released", 0, {31'h0, device_reset});
    apb(1'b0, 12'h008, 32'h0);
    chk("clock default", 32'h0004_ff02, rd);
  endtask
  ////////////////////////////////////////////////////////////////
  // Reset, then the scenarios in order
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cont();
    t_chop();
    t_standby();
    t_detect();
    t_reset();
    test_done();
  end
  // Hang guard, about 80k clocks
  initial begin
    #2000000;
    failures++;
    test_done();
  end
endmodule // ams_sequencer_tb
